/* rtl/lmmd_cfg.svh */
`ifndef LMMD_CFG_SVH
`define LMMD_CFG_SVH

// ----------------------------------------
// legacy segment boundaries
// ----------------------------------------
`define LMMD_LOW_TOP   32'h0009ffff
`define LMMD_VGA_TOP   32'h000bffff
`define LMMD_CROM_BASE 32'h000c0000
`define LMMD_DROM_BASE 32'h000d0000
`define LMMD_EROM_BASE 32'h000e0000
`define LMMD_BIOS_BASE 32'h000f0000
`define LMMD_EXT_BASE  32'h00100000
`define LMMD_VGA_A_TOP 32'h000affff
`define LMMD_VGA_B8    32'h000b8000

// ----------------------------------------
// shadow control register 3 fields
// ----------------------------------------
`define LMMD_S3_BIOS_RD   0
`define LMMD_S3_BIOS_WR   1
`define LMMD_S3_BIOS_C    2
`define LMMD_S3_C0_C      3
`define LMMD_S3_C4_C      4
`define LMMD_S3_CSEG_ROM  5
`define LMMD_S3_DSEG_ROM  6
`define LMMD_S3_ESEG_ROM  7

// ----------------------------------------
// vga memory map modes, reset values
// ----------------------------------------
`define LMMD_MAP_128K 2'h0
`define LMMD_MAP_A64K 2'h1
`define LMMD_MAP_B32K 2'h2
`define LMMD_MAP_B8K  2'h3
`define LMMD_ADDR_RST 32'h00000000

`endif

/* rtl/lmmd_pkg.sv */
package lmmd_pkg;

	// ----------------------------------------
	// enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		LMMD_M_HOST = 2'h0,
		LMMD_M_PCI  = 2'h1,
		LMMD_M_ISA  = 2'h2,
		LMMD_M_DMA  = 2'h3
	} lmmd_master_t;

	typedef enum logic [1:0] {
		LMMD_D_NONE = 2'h0,
		LMMD_D_MEM  = 2'h1,
		LMMD_D_PCI  = 2'h2,
		LMMD_D_ISA  = 2'h3
	} lmmd_dest_t;

	typedef enum logic [2:0] {
		LMMD_S_LOW   = 3'h0,
		LMMD_S_VGA   = 3'h1,
		LMMD_S_CROM  = 3'h2,
		LMMD_S_DROM  = 3'h3,
		LMMD_S_EROM  = 3'h4,
		LMMD_S_BIOS  = 3'h5,
		LMMD_S_ABOVE = 3'h6
	} lmmd_seg_kind_t;

	typedef enum logic [2:0] {
		LMMD_P_MEM     = 3'h0,
		LMMD_P_PCI_ISA = 3'h1,
		LMMD_P_SUB_MEM = 3'h2,
		LMMD_P_SUB_ISA = 3'h3,
		LMMD_P_PCI_DEV = 3'h4
	} lmmd_path_t;

	typedef enum logic [4:0] {
		LMMD_ST_IDLE = 5'h01,
		LMMD_ST_PCI  = 5'h02,
		LMMD_ST_MEM  = 5'h04,
		LMMD_ST_ISA  = 5'h08,
		LMMD_ST_DONE = 5'h10
	} lmmd_state_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		lmmd_master_t master;
		logic         write;
		logic [31:0]  addr;
	} lmmd_req_t;

	typedef struct packed {
		lmmd_seg_kind_t kind;
		logic [1:0]     piece;
	} lmmd_seg_t;

	typedef struct packed {
		lmmd_path_t path;
		logic       cacheable;
		logic       romEn;
	} lmmd_dec_t;

	typedef struct packed {
		logic [7:0] s0;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
	} lmmd_shadow_t;

	typedef struct packed {
		logic       enable;
		logic [1:0] mapMode;
	} lmmd_vga_t;

	typedef struct packed {
		logic       enable;
		logic [3:0] startMb;
		logic [3:0] endMb;
	} lmmd_hole_t;

endpackage

/* rtl/lmmd_reset_sync.sv */
module lmmd_reset_sync (
	// clock and raw reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// released copy
	output logic      rstnSync
);

	logic stage1_reg;

	// assert at once, release after two edges
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1_reg <= 1'b0;
			rstnSync   <= 1'b0;
		end else begin
			stage1_reg <= 1'b1;
			rstnSync   <= stage1_reg;
		end
	end

endmodule

/* rtl/lmmd_seg_class.sv */
`include "lmmd_cfg.svh"

module lmmd_seg_class
	import lmmd_pkg::*;
(
	// cycle address and memory limits
	input  wire logic [31:0] addr,
	input  wire logic [31:0] topOfMem,
	input  wire lmmd_hole_t  hole,
	// classification
	output lmmd_seg_t        seg
);

	logic inHole;

	// hole is 1M granular inside the first 16M
	assign inHole = hole.enable && (addr[31:24] == 8'h00) && (addr >= `LMMD_EXT_BASE)
	                && (addr[23:20] >= hole.startMb) && (addr[23:20] <= hole.endMb);

	// ordered compare, lowest segment first
	always_comb begin
		seg.piece = addr[15:14];
		if (addr <= `LMMD_LOW_TOP)
			seg.kind = LMMD_S_LOW;
		else if (addr <= `LMMD_VGA_TOP)
			seg.kind = LMMD_S_VGA;
		else if (addr < `LMMD_DROM_BASE)
			seg.kind = LMMD_S_CROM;
		else if (addr < `LMMD_EROM_BASE)
			seg.kind = LMMD_S_DROM;
		else if (addr < `LMMD_BIOS_BASE)
			seg.kind = LMMD_S_EROM;
		else if (addr < `LMMD_EXT_BASE)
			seg.kind = LMMD_S_BIOS;
		else if (inHole || (addr >= topOfMem))
			seg.kind = LMMD_S_ABOVE;
		else
			seg.kind = LMMD_S_LOW;
	end

endmodule

/* rtl/lmmd_decoder.sv */
`include "lmmd_cfg.svh"

module lmmd_decoder
	import lmmd_pkg::*;
(
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// cycle request
	input  wire logic         reqValid,
	input  wire lmmd_req_t    req,
	output logic              reqReady,
	// configuration
	input  wire lmmd_shadow_t shadow,
	input  wire lmmd_vga_t    vga,
	input  wire lmmd_hole_t   hole,
	input  wire logic [31:0]  topOfMem,
	// pci claim status
	input  wire logic         pciClaim,
	input  wire logic         pciNoClaim,
	// completion from memory and isa
	input  wire logic         memDone,
	input  wire logic         isaDone,
	// routing result
	output lmmd_dest_t        dest,
	output logic              cacheable,
	output logic              l1Snoop,
	output logic              boot_rom_select_n,
	output logic [31:0]       cycAddr,
	output logic [23:0]       isaAddr,
	output logic              cycWrite,
	// start strobes and end of cycle
	output logic              memStart,
	output logic              pciStart,
	output logic              isaStart,
	output logic              cycleDone,
	// isa ready pin and sd data enable
	output logic              ioChRdyOut,
	output logic              ioChRdyOe,
	output logic              sdDriveOe
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic         rstnSync;
	lmmd_seg_t    seg;
	lmmd_dec_t    dec;
	logic         reqTake;
	lmmd_state_t  state_reg;
	lmmd_state_t  state_next;
	lmmd_dec_t    dec_reg;
	lmmd_master_t master_reg;
	lmmd_master_t master_next;
	lmmd_dest_t   dest_next;
	logic         vgaOwns;

	// ----------------------------------------
	// reset release and segment lookup
	// ----------------------------------------
	lmmd_reset_sync uResetSync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.rstnSync (rstnSync)
	);

	lmmd_seg_class uSegClass (
		.addr     (req.addr),
		.topOfMem (topOfMem),
		.hole     (hole),
		.seg      (seg)
	);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// read or write enable of one 16K piece in a shadow register
	function automatic logic shadowBit(input logic [7:0] r, input logic [1:0] p, input logic wr);
		logic [2:0] idx;
		idx = {p, wr};
		return r[idx];
	endfunction

	// part of the video segment the frame buffer answers for
	function automatic logic vgaHit(input lmmd_vga_t v, input logic [31:0] a);
		logic hit;
		hit = 1'b0;
		case (v.mapMode)
			`LMMD_MAP_128K: hit = 1'b1;
			`LMMD_MAP_A64K: hit = (a <= `LMMD_VGA_A_TOP);
			`LMMD_MAP_B32K: hit = (a > `LMMD_VGA_A_TOP) && (a < `LMMD_VGA_B8);
			`LMMD_MAP_B8K:  hit = (a >= `LMMD_VGA_B8);
			default:        hit = 1'b0;
		endcase
		return v.enable && hit;
	endfunction

	assign vgaOwns = vgaHit(vga, req.addr);

	// ----------------------------------------
	// routing decision for the offered cycle
	// ----------------------------------------
	// address, direction, master
	always_comb begin
		logic toMem;
		logic [7:0] s3;
		toMem         = 1'b0;
		s3            = shadow.s3;
		dec.cacheable = 1'b0;
		dec.romEn     = 1'b0;
		case (seg.kind)
			LMMD_S_LOW: begin
				toMem         = 1'b1;
				dec.cacheable = 1'b1;
			end
			LMMD_S_VGA: begin
				toMem         = vgaOwns;
				dec.cacheable = 1'b0;
			end
			LMMD_S_CROM: begin
				toMem         = shadowBit(shadow.s0, seg.piece, req.write);
				dec.romEn     = s3[`LMMD_S3_CSEG_ROM];
				case (seg.piece)
					2'h0:    dec.cacheable = toMem & s3[`LMMD_S3_C0_C];
					2'h1:    dec.cacheable = toMem & s3[`LMMD_S3_C4_C];
					default: dec.cacheable = 1'b0;
				endcase
			end
			// per piece shadow, one rom setting
			LMMD_S_DROM: begin
				toMem     = shadowBit(shadow.s1, seg.piece, req.write);
				dec.romEn = s3[`LMMD_S3_DSEG_ROM];
			end
			// per piece shadow, one rom setting
			LMMD_S_EROM: begin
				toMem     = shadowBit(shadow.s2, seg.piece, req.write);
				dec.romEn = s3[`LMMD_S3_ESEG_ROM];
			end
			LMMD_S_BIOS: begin
				toMem         = req.write ? s3[`LMMD_S3_BIOS_WR] : s3[`LMMD_S3_BIOS_RD];
				dec.cacheable = toMem & s3[`LMMD_S3_BIOS_C];
				dec.romEn     = 1'b1;
			end
			// above memory or in the hole
			LMMD_S_ABOVE: begin
				toMem = 1'b0;
			end
			default: begin
				toMem = 1'b0;
			end
		endcase
		// forwarding depends on who runs the cycle
		case (req.master)
			// host: memory, or pci then isa
			LMMD_M_HOST: dec.path = toMem ? LMMD_P_MEM : LMMD_P_PCI_ISA;
			// pci master waits for the claim window
			LMMD_M_PCI:  dec.path = toMem ? LMMD_P_SUB_MEM : LMMD_P_SUB_ISA;
			default:     dec.path = toMem ? LMMD_P_MEM : LMMD_P_PCI_DEV;
		endcase
	end

	assign reqTake = reqValid && reqReady;

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	// next state; claim beats no-claim if both arrive together
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LMMD_ST_IDLE: begin
				if (reqTake)
					state_next = (dec.path == LMMD_P_MEM) ? LMMD_ST_MEM : LMMD_ST_PCI;
			end
			LMMD_ST_PCI: begin
				if (pciClaim)
					state_next = LMMD_ST_DONE;
				else if (pciNoClaim) begin
					case (dec_reg.path)
						LMMD_P_SUB_MEM: state_next = LMMD_ST_MEM;
						LMMD_P_PCI_DEV: state_next = LMMD_ST_DONE;
						default:        state_next = LMMD_ST_ISA;
					endcase
				end
			end
			LMMD_ST_MEM: begin
				if (memDone)
					state_next = LMMD_ST_DONE;
			end
			LMMD_ST_ISA: begin
				if (isaDone)
					state_next = LMMD_ST_DONE;
			end
			LMMD_ST_DONE: begin
				state_next = LMMD_ST_IDLE;
			end
			default: begin
				state_next = LMMD_ST_IDLE;
			end
		endcase
	end

	// master of the cycle in flight, fresh one while idle
	assign master_next = reqTake ? req.master : master_reg;

	// destination shown at the ports
	always_comb begin
		dest_next = dest;
		if (reqTake)
			dest_next = (dec.path == LMMD_P_MEM) ? LMMD_D_MEM : LMMD_D_PCI;
		else if (state_reg == LMMD_ST_PCI && !pciClaim && pciNoClaim)
			dest_next = (dec_reg.path == LMMD_P_SUB_MEM) ? LMMD_D_MEM : LMMD_D_ISA;
	end

	// state register
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync)
			state_reg <= LMMD_ST_IDLE;
		else
			state_reg <= state_next;
	end

	// captured decision, held for the whole cycle
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			dec_reg    <= '0;
			master_reg <= LMMD_M_HOST;
			cycAddr    <= `LMMD_ADDR_RST;
			cycWrite   <= 1'b0;
			cacheable  <= 1'b0;
		end else if (reqTake) begin
			dec_reg    <= dec;
			master_reg <= req.master;
			cycAddr    <= req.addr;
			cycWrite   <= req.write;
			cacheable  <= dec.cacheable;
		end
	end

	// isa sees only the low 16M
	assign isaAddr = cycAddr[23:0];

	// destination and acceptance
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			dest     <= LMMD_D_NONE;
			reqReady <= 1'b0;
		end else begin
			dest     <= dest_next;
			reqReady <= (state_next == LMMD_ST_IDLE);
		end
	end

	// ----------------------------------------
	// start strobes
	// ----------------------------------------
	// one-cycle pulses on entry into a wait state
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			memStart  <= 1'b0;
			pciStart  <= 1'b0;
			isaStart  <= 1'b0;
			cycleDone <= 1'b0;
		end else begin
			memStart  <= (state_next == LMMD_ST_MEM) && (state_reg != LMMD_ST_MEM);
			// pci masters already own the pci cycle
			pciStart  <= (state_next == LMMD_ST_PCI) && (state_reg == LMMD_ST_IDLE)
			             && (master_next != LMMD_M_PCI);
			// unclaimed host or pci cycle moves to isa
			isaStart  <= (state_next == LMMD_ST_ISA) && (state_reg != LMMD_ST_ISA);
			cycleDone <= (state_next == LMMD_ST_DONE);
		end
	end

	// ----------------------------------------
	// cache and rom select
	// ----------------------------------------
	// rom select while dest is isa: in the isa state, and in the done cycle after isa or after an unclaimed dma or isa master cycle
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			boot_rom_select_n <= 1'b1;
			l1Snoop           <= 1'b0;
		end else begin
			boot_rom_select_n <= !(dec_reg.romEn && (dest_next == LMMD_D_ISA)
			                       && (state_next == LMMD_ST_ISA || state_next == LMMD_ST_DONE));
			// bus masters into cacheable memory snoop L1
			// captured copies are one cycle late on the take edge, so read the fresh decision there
			l1Snoop           <= (state_next == LMMD_ST_MEM) && (reqTake ? dec.cacheable : cacheable)
			                     && (master_next == LMMD_M_PCI || master_next == LMMD_M_ISA);
		end
	end

	// ----------------------------------------
	// isa side pins
	// ----------------------------------------
	// ready pulled low only, never driven high
	always_ff @(posedge clk_sys or negedge rstnSync) begin
		if (!rstnSync) begin
			ioChRdyOut <= 1'b0;
			ioChRdyOe  <= 1'b0;
			sdDriveOe  <= 1'b0;
		end else begin
			ioChRdyOut <= 1'b0;
			// stretch isa master cycle while waiting
			ioChRdyOe  <= (master_next == LMMD_M_ISA)
			              && (state_next == LMMD_ST_PCI || state_next == LMMD_ST_MEM);
			// dma read data driven from memory
			sdDriveOe  <= (master_next == LMMD_M_DMA) && (dest_next == LMMD_D_MEM)
			              && !(reqTake ? req.write : cycWrite)
			              && (state_next == LMMD_ST_MEM || state_next == LMMD_ST_DONE);
		end
	end

endmodule

/* sim/lmmd_decoder_sva.sv */
`include "lmmd_cfg.svh"

module lmmd_decoder_sva
	import lmmd_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// request side
	input wire logic        reqValid,
	input wire lmmd_req_t   req,
	input wire logic        reqReady,
	input wire lmmd_vga_t   vga,
	input wire logic [31:0] topOfMem,
	// results
	input wire lmmd_dest_t  dest,
	input wire logic        cacheable,
	input wire logic        l1Snoop,
	input wire logic        boot_rom_select_n,
	input wire logic [31:0] cycAddr,
	input wire logic        memStart,
	input wire logic        pciStart,
	input wire logic        isaStart,
	input wire logic        ioChRdyOut,
	input wire logic        ioChRdyOe,
	input wire logic        sdDriveOe
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// take strobe and address classes
	logic tk, hostT, low, vidA, fixA;
	assign tk = reqValid && reqReady;
	assign hostT = tk && req.master == LMMD_M_HOST;
	assign low = req.addr <= `LMMD_LOW_TOP;
	assign vidA = req.addr > `LMMD_LOW_TOP && req.addr <= `LMMD_VGA_TOP;
	assign fixA = req.addr >= 32'h000c8000 && req.addr < `LMMD_BIOS_BASE;

	// remembers a dma read, since cycWrite alone cannot tell the master
	logic dmaRdReg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			dmaRdReg <= 1'b0;
		else if (tk)
			dmaRdReg <= req.master == LMMD_M_DMA && !req.write;
	end

	a_host_low_mem: assert property (hostT && low |=> memStart && !pciStart && dest == LMMD_D_MEM)
		else $error("host low cycle not sent to memory");
	a_pci_low_sub: assert property (tk && req.master == LMMD_M_PCI && low |=> !pciStart && !memStart && dest == LMMD_D_PCI)
		else $error("pci low cycle skipped subtractive decode");
	a_isa_snoop_l1: assert property (tk && req.master == LMMD_M_ISA && low |=> l1Snoop)
		else $error("isa master low cycle without L1 snoop");
	a_isa_hold_rdy: assert property (tk && req.master == LMMD_M_ISA |=> ioChRdyOe && !ioChRdyOut)
		else $error("isa master not held waiting");
	a_dma_sd_drive: assert property (memStart && dmaRdReg |=> sdDriveOe)
		else $error("dma read does not drive data bus");
	a_low_cacheable: assert property (tk && low |=> cacheable)
		else $error("low range not cacheable");
	a_vga_no_cache: assert property (tk && vidA |=> !cacheable)
		else $error("video segment cacheable");
	a_fixed_no_cache: assert property (tk && fixA |=> !cacheable)
		else $error("fixed segment cacheable");
	a_bios_rom_sel: assert property (isaStart && cycAddr[31:16] == 16'h000f |-> !boot_rom_select_n)
		else $error("bios isa cycle without rom select");
	a_above_pci: assert property (hostT && req.addr >= topOfMem |=> pciStart && dest == LMMD_D_PCI)
		else $error("cycle above memory not sent to pci");
	a_vga_off_pci: assert property (hostT && vidA && !vga.enable |=> pciStart)
		else $error("disabled video cycle not sent to pci");
endmodule

bind lmmd_decoder lmmd_decoder_sva u_lmmd_decoder_sva (.clk_sys, .rstn, .reqValid, .req, .reqReady, .vga,
	.topOfMem, .dest, .cacheable, .l1Snoop, .boot_rom_select_n, .cycAddr, .memStart, .pciStart, .isaStart,
	.ioChRdyOut, .ioChRdyOe, .sdDriveOe);

/* sim/lmmd_partner.sv */
module lmmd_partner
	import lmmd_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// far side behaviour
	input  wire logic       claimMode,
	input  wire logic [1:0] lat,
	// start strobes
	input  wire logic       pciStart,
	// a pci master runs its own bus cycle, so the claim window opens without pciStart
	input  wire logic       pciOwn,
	input  wire logic       memStart,
	input  wire logic       isaStart,
	// answers
	output logic            pciClaim,
	output logic            pciNoClaim,
	output logic            memDone,
	output logic            isaDone
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [1:0] kindReg, cntReg;

	// one job at a time; answer comes lat+1 cycles after its start
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			kindReg <= 2'h0;
			cntReg <= 2'h0;
			{pciClaim, pciNoClaim, memDone, isaDone} <= 4'h0;
		end else begin
			{pciClaim, pciNoClaim, memDone, isaDone} <= 4'h0;
			if (pciStart || pciOwn || memStart || isaStart) begin
				kindReg <= (pciStart || pciOwn) ? 2'h1 : (memStart ? 2'h2 : 2'h3);
				cntReg <= lat;
			end else if (kindReg != 2'h0 && cntReg != 2'h0) begin
				cntReg <= cntReg - 2'h1;
			end else if (kindReg != 2'h0) begin
				kindReg <= 2'h0;
				pciClaim <= kindReg == 2'h1 && claimMode;
				pciNoClaim <= kindReg == 2'h1 && !claimMode;
				memDone <= kindReg == 2'h2;
				isaDone <= kindReg == 2'h3;
			end
		end
	end
endmodule

/* sim/lmmd_decoder_bench.sv */
`include "lmmd_cfg.svh"

module lmmd_decoder_bench
	import lmmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic         clk_sys, rstn, reqValid, reqReady, claimMode;
	lmmd_req_t    req;
	lmmd_shadow_t shadow;
	lmmd_vga_t    vga;
	lmmd_hole_t   hole;
	logic [31:0]  topOfMem, cycAddr;
	logic [1:0]   lat;
	lmmd_dest_t   dest;
	logic         pciClaim, pciNoClaim, memDone, isaDone, cacheable, boot_rom_select_n;
	logic         memStart, pciStart, isaStart, cycleDone, ioChRdyOut, ioChRdyOe, sdDriveOe;
	logic         l1Snoop, cycWrite, pmStart;
	logic [23:0]  isaAddr;
	int           nMismatch, comparisons, cycles;
	logic [31:0]  corner[10] = '{32'h0009ffff, 32'h000a0000, 32'h000bffff, 32'h000c0000, 32'h000c7fff,
		32'h000effff, 32'h000fffff, 32'h00100000, 32'h003fffff, 32'h00400000};
	logic [31:0]  bases[20] = '{32'h0, 32'h9c000, 32'ha0000, 32'hac000, 32'hb0000, 32'hb8000, 32'hc0000,
		32'hc4000, 32'hc8000, 32'hcc000, 32'hd0000, 32'hdc000, 32'he4000, 32'hec000, 32'hf0000,
		32'h100000, 32'h3fc000, 32'h400000, 32'hffff0000, 32'hfc000};

	lmmd_decoder u_lmmd_decoder (.clk_sys, .rstn, .reqValid, .req, .reqReady, .shadow, .vga, .hole,
		.topOfMem, .pciClaim, .pciNoClaim, .memDone, .isaDone, .dest, .cacheable, .l1Snoop,
		.boot_rom_select_n, .cycAddr, .isaAddr, .cycWrite, .memStart, .pciStart, .isaStart,
		.cycleDone, .ioChRdyOut, .ioChRdyOe, .sdDriveOe);
	lmmd_partner u_lmmd_partner (.clk_sys, .rstn, .claimMode, .lat, .pciStart, .pciOwn(pmStart), .memStart,
		.isaStart, .pciClaim, .pciNoClaim, .memDone, .isaDone);

	// pci master cycles get no pciStart; tell the far side that the claim window is open
	always_ff @(posedge clk_sys)
		pmStart <= reqValid && reqReady && req.master == LMMD_M_PCI;

	// free running clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chkD(input lmmd_dest_t got, input lmmd_dest_t exp);
		comparisons++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected dest at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkB(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkA(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected address at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, nMismatch);
		if (nMismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// returns mapped, cacheable known, cacheable, rom enable
	function automatic logic [3:0] expAttr(input logic [31:0] a, input logic w);
		logic [2:0] i;
		logic       m;
		logic       inH;
		i = {a[15:14], w};
		case (vga.mapMode)
			`LMMD_MAP_128K: m = 1'b1;
			`LMMD_MAP_A64K: m = a <= `LMMD_VGA_A_TOP;
			`LMMD_MAP_B32K: m = a[16] && !a[15];
			default: m = a >= `LMMD_VGA_B8;
		endcase
		inH = hole.enable && a[31:24] == 8'h0 && a[23:20] >= hole.startMb && a[23:20] <= hole.endMb;
		if (a <= `LMMD_LOW_TOP) return 4'he;
		if (a <= `LMMD_VGA_TOP) return {vga.enable && m, 3'h4};
		if (a < `LMMD_DROM_BASE)
			return {shadow.s0[i], a[15] || shadow.s0[i], !a[15] && shadow.s3[3 + a[14]], shadow.s3[5]};
		if (a < `LMMD_EROM_BASE) return {shadow.s1[i], 2'h2, shadow.s3[6]};
		if (a < `LMMD_BIOS_BASE) return {shadow.s2[i], 2'h2, shadow.s3[7]};
		if (a < `LMMD_EXT_BASE) return {shadow.s3[w], shadow.s3[w], shadow.s3[2], 1'b1};
		return (a < topOfMem && !inH) ? 4'he : 4'h0;
	endfunction

	// one whole cycle with random master, direction and configuration
	task automatic run(input logic [31:0] a);
		logic [3:0] e;
		lmmd_dest_t d;
		@(negedge clk_sys);
		req.addr = a;
		req.master = lmmd_master_t'(2'($urandom));
		req.write = 1'($urandom);
		shadow = $urandom;
		vga = 3'($urandom);
		hole.enable = 1'($urandom);
		claimMode = 1'($urandom);
		lat = 2'($urandom);
		reqValid = 1'b1;
		e = expAttr(a, req.write);
		if (e[3])
			d = (req.master == LMMD_M_PCI && claimMode) ? LMMD_D_PCI : LMMD_D_MEM;
		else
			d = claimMode ? LMMD_D_PCI : LMMD_D_ISA;
		for (int k = 0; k < 64 && reqReady !== 1'b1; k++) @(negedge clk_sys);
		@(negedge clk_sys);
		reqValid = 1'b0;
		if (e[2]) chkB(cacheable, e[1]);
		chkB(cycWrite, req.write);
		chkA(cycAddr, a);
		chkA({8'h00, isaAddr}, {8'h00, a[23:0]});
		chkB(l1Snoop, req.master == LMMD_M_ISA && e[3] && e[1]);
		for (int k = 0; k < 64 && cycleDone !== 1'b1; k++) @(negedge clk_sys);
		chkD(dest, d);
		chkB(boot_rom_select_n, !(d == LMMD_D_ISA && e[0]));
	endtask

	// hang guard, well above the few thousand cycles needed
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			conclude();
		end
	end

	initial begin
		rstn = 1'b0;
		reqValid = 1'b0;
		req = '0;
		shadow = '0;
		vga = '0;
		hole = '0;
		hole.startMb = 4'h3;
		hole.endMb = 4'h3;
		topOfMem = 32'h00400000;
		claimMode = 1'b0;
		lat = 2'h0;
		void'($urandom(32'h88ca3d3e));
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		foreach (corner[j]) run(corner[j]);
		$display("corner test done");
		repeat (300) run(bases[$urandom_range(19)] | ($urandom & 32'h3fff));
		$display("random test done");
		conclude();
	end
endmodule
